// ---- test/pse_gate_drv.sv ----
/*
  pse_gate_drv: gate driver stand-in, measures each pulse width in clocks.
  assumes pwm levels registered on the same clock.
*/
`timescale 1ns/1ps
module pse_gate_drv (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic [7:0]      pwm_in,
  output logic      [7:0][7:0] on_len_out
);
  logic [7:0][7:0] cnt;
  // count high clocks, latch the width at each turn-off
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      on_len_out <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pwm_in[i]) begin
          cnt[i] <= cnt[i] + 8'h01;
        end else if (cnt[i] != 8'h00) begin
          on_len_out[i] <= cnt[i];
          cnt[i] <= 8'h00;
        end
      end
    end
  end
endmodule

// ---- test/pse_top_sva.sv ----
/*
  pse_top_sva: port checks for pse_top.
  assumes binding to pse_top; shadows follow the register writes.
*/
`timescale 1ns/1ps
module pse_top_sva (
  input  wire logic                     ref_clk_in,
  input  wire logic                     arst_n_in,
  input  wire pse_pkg::pse_bus_t        bus_in,
  input  wire logic [7:0]               rdata_out,
  input  wire logic                     sync_lock_in,
  input  wire pse_pkg::pse_edge_t [7:0] edges_in,
  input  wire logic                     sr_start_in,
  input  wire logic [3:0]               sr_busy_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [7:0] sd;
  logic [7:0] adj;
  logic [7:0] srs;
  wire logic  hit = bus_in.addr inside {pse_pkg::ADDR_SHUTDOWN, pse_pkg::ADDR_ADJUST,
                                        pse_pkg::ADDR_SR_SOFT, pse_pkg::ADDR_STATUS};
  // shadow copies of the writable registers
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sd <= 8'h00;
      adj <= 8'h00;
      srs <= 8'h00;
    end else if (bus_in.wr) begin
      if (bus_in.addr == pse_pkg::ADDR_SHUTDOWN) sd <= bus_in.wdata;
      if (bus_in.addr == pse_pkg::ADDR_ADJUST) adj <= bus_in.wdata;
      if (bus_in.addr == pse_pkg::ADDR_SR_SOFT) srs <= bus_in.wdata;
    end
  end
  property p_idle; !$past(bus_in.rd) |-> rdata_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside a read");
  property p_adj; bus_in.rd && bus_in.addr == pse_pkg::ADDR_ADJUST |=> rdata_out == adj;
  endproperty
  a_adj: assert property (p_adj) else $error("adjust readback wrong");
  property p_sd; bus_in.rd && bus_in.addr == pse_pkg::ADDR_SHUTDOWN |=> rdata_out == sd;
  endproperty
  a_sd: assert property (p_sd) else $error("shutdown readback wrong");
  property p_srs; bus_in.rd && bus_in.addr == pse_pkg::ADDR_SR_SOFT |=> rdata_out == srs;
  endproperty
  a_srs: assert property (p_srs) else $error("soft start readback wrong");
  property p_unmap; bus_in.rd && !hit |=> rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_en; (sr_busy_out & ~($past(srs[3:0]) | $past(srs[3:0], 2))) == 4'h0;
  endproperty
  a_en: assert property (p_en) else $error("ramp busy on disabled slot");
  property p_go;
    sr_start_in && srs[0] && edges_in[2].fall != edges_in[2].rise |=> sr_busy_out[0];
  endproperty
  a_go: assert property (p_go) else $error("ramp did not start");
  property p_st;
    bus_in.rd && bus_in.addr == pse_pkg::ADDR_STATUS
      |=> rdata_out[4:0] == {$past(sr_busy_out), $past(sync_lock_in)};
  endproperty
  a_st: assert property (p_st) else $error("status read wrong");
endmodule
bind pse_top pse_top_sva u_sva (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .sync_lock_in(sync_lock_in),
  .edges_in(edges_in), .sr_start_in(sr_start_in), .sr_busy_out(sr_busy_out));

// ---- test/tb_pwm_sync_edge_adjust_sr_softstart.sv ----
/*
  tb_pwm_sync_edge_adjust_sr_softstart: scenario bench for pse_top.
  assumes 5 ns edge units and 25 ns clock.
*/
`timescale 1ns/1ps
module tb_pwm_sync_edge_adjust_sr_softstart;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  pse_pkg::pse_bus_t bus = '0;
  logic [7:0] rdata;
  logic lock = 1'b0;
  logic [15:0] ts = 16'h0064;
  logic [15:0] tsy = 16'h0050;
  pse_pkg::pse_edge_t [7:0] edges = '0;
  logic sr_start = 1'b0;
  logic [7:0] pwm;
  logic [3:0] busy;
  logic [7:0][7:0] on_len;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  pse_top u_dut (.ref_clk_in(clk), .arst_n_in(arst_n), .bus_in(bus), .rdata_out(rdata),
    .sync_lock_in(lock), .channel_cycle_time_in(ts), .sync_cycle_time_in(tsy),
    .edges_in(edges), .sr_start_in(sr_start), .pwm_out(pwm), .sr_busy_out(busy));
  pse_gate_drv u_drv (.clk_in(clk), .rst_n_in(arst_n), .pwm_in(pwm), .on_len_out(on_len));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic set_edges(input logic [15:0] f);
    @(posedge clk);
    for (int i = 0; i < 8; i++) edges[i] <= '{rise: 16'h0000, fall: f, half_phase: 1'b0};
  endtask
  task automatic t_regs();
    logic [7:0] d;
    logic [15:0] a;
    for (int i = 0; i < 3; i++) begin
      a = pse_pkg::ADDR_SHUTDOWN + 16'(i);
      rd(a, d);
      chk("reg_reset", 16'(d), 16'h0000);
      wr(a, 8'ha5);
      rd(a, d);
      chk("reg_back", 16'(d), 16'h00a5);
      wr(a, 8'h00);
    end
    rd(16'hfe60, d);
    chk("unmapped", 16'(d), 16'h0000);
  endtask
  task automatic t_ontime();
    set_edges(16'h0014);
    repeat (70) @(posedge clk);
    chk("on_free", 16'(on_len[0]), 16'h0004);
    lock <= 1'b1;
    repeat (70) @(posedge clk);
    chk("on_lock", 16'(on_len[0]), 16'h0004);
    chk("on_lock2", 16'(on_len[5]), 16'h0004);
  endtask
  task automatic t_adjust();
    logic [7:0] av [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
    int n;
    edges[1].half_phase <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(pse_pkg::ADDR_ADJUST, av[k]);
      repeat (40) @(posedge clk);
      @(negedge pwm[0]);
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (pwm[1] !== 1'b1 && n < 100);
      if (av[k][1]) chk("gap_adj", 16'(n), (ts / 2 - 16'h0014) / 5);
      else chk("gap_raw", 16'(n), (tsy / 2 - 16'h0014) / 5);
      // the shifted pulse must keep its programmed width
      repeat (20) @(posedge clk);
      #1 chk("on_adj", 16'(on_len[1]), 16'h0004);
    end
    wr(pse_pkg::ADDR_ADJUST, 8'h00);
  endtask
  task automatic t_kill();
    int hi [2];
    logic [7:0] d;
    edges[1].half_phase <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      wr(pse_pkg::ADDR_SHUTDOWN, b ? 8'h40 : 8'h80);
      repeat (40) @(posedge clk);
      hi = '{0, 0};
      repeat (16) begin
        @(posedge clk);
        #1 hi[0] += pwm[0];
        hi[1] += pwm[1];
      end
      chk("victim", 16'(hi[1 - b]), 16'h0000);
      chk("keeper", 16'(hi[b]), 16'h0004);
      // status shows the lock and the kill flag of the victim
      rd(pse_pkg::ADDR_STATUS, d);
      chk("kill_stat", 16'(d), b ? 16'h0021 : 16'h0041);
      wr(pse_pkg::ADDR_SHUTDOWN, 8'h00);
    end
  endtask
  task automatic t_soft();
    int n;
    int dv;
    lock <= 1'b0;
    set_edges(16'h0028);
    for (int j = 0; j < 5; j++) begin
      dv = 1 << (2 * (j % 4));
      wr(pse_pkg::ADDR_SR_SOFT, j < 4 ? 8'((j << 4) | 1) : 8'h08);
      @(posedge clk);
      sr_start <= 1'b1;
      @(posedge clk);
      sr_start <= 1'b0;
      #1 chk("busy_on", 16'(busy), j < 4 ? 16'h0001 : 16'h0008);
      n = 0;
      while (busy !== 4'h0 && n < 7000) begin
        @(posedge clk);
        #1 n++;
      end
      if (j < 4) chk("ramp_len", 16'(n / (20 * dv) >= 4 && n / (20 * dv) <= 5), 16'h0001);
      // ramp finished: the rectifier pulse is back at its full width
      repeat (45) @(posedge clk);
      #1 chk("sr_width", 16'(on_len[j < 4 ? 2 : 7]), 16'h0008);
    end
    wr(pse_pkg::ADDR_SR_SOFT, 8'h00);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_ontime();
    t_adjust();
    t_kill();
    t_soft();
    test_done();
  end
endmodule

// ---- verilog/pse_pkg.sv ----
/*
  pse_pkg: constants, register map and carrier types for the pwm sync
  edge adjust and rectifier soft-start block.
  assumes a 40 MHz system clock and edge times given in 5 ns units.
*/
package pse_pkg;

  // clock and time base
  localparam int CLK_NS      = 25;                 // system clock period
  localparam int POS_NS      = 5;                  // unit of all edge positions
  localparam int SR_STEP_NS  = 40;                 // rectifier rising edge step
  localparam logic [15:0] CNT_STEP    = 16'(CLK_NS / POS_NS);
  localparam logic [15:0] SR_STEP_POS = 16'(SR_STEP_NS / POS_NS);

  // register offsets
  localparam logic [15:0] ADDR_SHUTDOWN = 16'hfe65; // sync_output_shutdown
  localparam logic [15:0] ADDR_ADJUST   = 16'hfe66; // sync_edge_adjust_enable
  localparam logic [15:0] ADDR_SR_SOFT  = 16'hfe67; // rectifier_soft_start
  localparam logic [15:0] ADDR_STATUS   = 16'hfe6f; // block status, read only

  // reset values
  localparam logic [7:0] RST_SHUTDOWN = 8'h00;
  localparam logic [7:0] RST_ADJUST   = 8'h00;
  localparam logic [7:0] RST_SR_SOFT  = 8'h00;

  // field positions
  localparam int SD_PWM_OUTPUT_2_BIT  = 7;                 // kill output 2 at output 1 start
  localparam int SD_PWM_OUTPUT_1_BIT  = 6;                 // kill output 1 at output 2 start
  localparam int SR_RATE_HI   = 5;
  localparam int SR_RATE_LO   = 4;
  localparam int SR_EN_HI     = 3;
  localparam int SR_EN_LO     = 0;
  localparam int ST_SYNC_BIT  = 0;                 // status: sync lock active
  localparam int ST_BUSY_LO   = 1;                 // status: ramp busy, bits 4..1
  localparam int ST_KILL_LO   = 5;                 // status: kill flags, bits 6..5

  // rectifier slots: slot 0..3 drive outputs 3, 4, 7, 8 (zero based 2, 3, 6, 7)
  localparam int NUM_OUT = 8;
  localparam int NUM_SR  = 4;
  localparam logic [3:0][2:0] SR_OUT_IDX = {3'h7, 3'h6, 3'h3, 3'h2};

  // rectifier step divider limits: 1, 4, 16, 64 switching cycles
  localparam logic [3:0][5:0] SR_DIV_LIMIT = {6'h3f, 6'h0f, 6'h03, 6'h00};

  // programmed timing of one output, positions from its cycle start
  typedef struct packed {
    logic [15:0] rise;
    logic [15:0] fall;
    logic        half_phase;                       // output runs half a cycle late
  } pse_edge_t;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } pse_bus_t;

endpackage

// ---- verilog/pse_step_gen.sv ----
/*
  pse_step_gen: turns switching cycle start pulses into rectifier step
  pulses, one per 1, 4, 16 or 64 cycles as the rate code selects.
  assumes cycle starts are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module pse_step_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       cyc_start_in,
  input  wire logic [1:0] rate_in,
  output logic            step_out
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       step;
  } pse_step_state_t;

  pse_step_state_t st;
  pse_step_state_t next_st;

  // count cycle starts, fire at the selected limit
  always_comb begin
    next_st      = st;
    next_st.step = 1'b0;
    if (cyc_start_in) begin
      if (st.cnt >= pse_pkg::SR_DIV_LIMIT[rate_in]) begin
        next_st.cnt  = 6'h00;
        next_st.step = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 6'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign step_out = st.step;

endmodule

// ---- verilog/pse_top.sv ----
/*
  pse_top: pwm output timing for synchronized channels. shifts edges of
  selected outputs while locked, cross-shuts outputs 1 and 2, and ramps
  rectifier rising edges left during soft start.
  assumes all inputs except arst_n_in synchronous to ref_clk_in and edge times in 5 ns units.
*/
`timescale 1ns/1ps
module pse_top (
  input  wire logic                  ref_clk_in,
  input  wire logic                  arst_n_in,
  input  wire pse_pkg::pse_bus_t     bus_in,
  output logic [7:0]                 rdata_out,
  input  wire logic                  sync_lock_in,
  input  wire logic [15:0]           channel_cycle_time_in,
  input  wire logic [15:0]           sync_cycle_time_in,
  input  wire pse_pkg::pse_edge_t [7:0] edges_in,
  input  wire logic                  sr_start_in,
  output logic [7:0]                 pwm_out,
  output logic [3:0]                 sr_busy_out
);

  // state of the block, apart from the reset flip-flops and the step generator u_step
  typedef struct packed {
    logic [7:0]        shutdown;
    logic [7:0]        adjust;
    logic [7:0]        sr_soft;
    logic [7:0]        rdata;
    logic [15:0]       cnt;
    logic              cyc_start;
    logic [1:0]        kill;       // bit 0 kills output 1, bit 1 kills output 2
    logic [3:0][15:0]  sr_off;     // extra rising edge delay per rectifier slot
    logic [3:0]        sr_busy;
    logic [7:0]        pwm;
  } pse_state_t;

  pse_state_t st;
  pse_state_t next_st;

  logic        rst_meta;
  logic        rst_sync_n;
  logic        sr_step;
  logic [15:0] period;
  logic [15:0] half_sync;
  logic [15:0] half_own;
  logic [7:0]  on_now;
  logic [7:0]  start_hit;
  logic [7:0][15:0] sr_off_out;
  logic [15:0] cnt_plus;
  logic [3:0][15:0] sr_width;

  // reset release through two flip-flops
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // wrap a position into the running period
  function automatic logic [15:0] wrap_pos(input logic [16:0] pos, input logic [15:0] per);
    logic [16:0] red;
    red = pos;
    if (red >= {1'b0, per}) begin
      red = red - {1'b0, per};
    end
    if (red >= {1'b0, per}) begin
      red = red - {1'b0, per};
    end
    return red[15:0];
  endfunction

  // running period follows the sync cycle while locked
  assign period    = sync_lock_in ? sync_cycle_time_in : channel_cycle_time_in;
  assign half_sync = {1'b0, period[15:1]};
  assign half_own  = {1'b0, channel_cycle_time_in[15:1]};
  assign cnt_plus  = st.cnt + pse_pkg::CNT_STEP;

  // per-output edge placement and on/off decision
  generate
    for (genvar i = 0; i < pse_pkg::NUM_OUT; i++) begin : g_out
      logic [15:0] half;
      logic [15:0] base;
      logic [15:0] rise_pos;
      logic [15:0] fall_pos;
      // adjusted outputs measure the half cycle from their own cycle time
      assign half = (sync_lock_in && st.adjust[i]) ? half_own : half_sync;
      // half-phase outputs start half a cycle late
      assign base = edges_in[i].half_phase ? half : 16'h0000;
      // both edges move by base, so on time is kept; only the rise also adds the rectifier delay sr_off_out
      assign rise_pos = wrap_pos({1'b0, edges_in[i].rise} + {1'b0, base}
                                 + {1'b0, sr_off_out[i]}, period);
      assign fall_pos = wrap_pos({1'b0, edges_in[i].fall} + {1'b0, base}, period);
      // high between rise and fall, wrapping across the cycle end
      assign on_now[i] = (rise_pos <= fall_pos)
                         ? (st.cnt >= rise_pos && st.cnt < fall_pos)
                         : (st.cnt >= rise_pos || st.cnt < fall_pos);
      // this output's own cycle start falls in the current clock slot
      assign start_hit[i] = (base >= st.cnt) && (base < cnt_plus);
    end
  endgenerate

  // rectifier delay routed onto its output, zero elsewhere
  always_comb begin
    sr_off_out = '0;
    for (int j = 0; j < pse_pkg::NUM_SR; j++) begin
      sr_off_out[pse_pkg::SR_OUT_IDX[j]] = st.sr_off[j];
    end
  end

  // programmed on width of each rectifier output, start point of its ramp
  always_comb begin
    for (int j = 0; j < pse_pkg::NUM_SR; j++) begin
      sr_width[j] = wrap_pos({1'b0, edges_in[pse_pkg::SR_OUT_IDX[j]].fall}
                             + {1'b0, period}
                             - {1'b0, edges_in[pse_pkg::SR_OUT_IDX[j]].rise}, period);
    end
  end

  // step pulses for the rectifier ramp
  pse_step_gen u_step (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_sync_n),
    .cyc_start_in (st.cyc_start),
    .rate_in      (st.sr_soft[pse_pkg::SR_RATE_HI:pse_pkg::SR_RATE_LO]),
    .step_out     (sr_step)
  );

  // next state of the whole block
  always_comb begin
    next_st           = st;
    next_st.rdata     = 8'h00;
    next_st.cyc_start = 1'b0;

    // register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        pse_pkg::ADDR_SHUTDOWN: next_st.shutdown = bus_in.wdata;
        pse_pkg::ADDR_ADJUST:   next_st.adjust   = bus_in.wdata;
        pse_pkg::ADDR_SR_SOFT:  next_st.sr_soft  = bus_in.wdata;
        default:                next_st.shutdown = st.shutdown;
      endcase
    end

    // register reads, answered in the following cycle
    if (bus_in.rd) begin
      case (bus_in.addr)
        pse_pkg::ADDR_SHUTDOWN: next_st.rdata = st.shutdown;
        pse_pkg::ADDR_ADJUST:   next_st.rdata = st.adjust;
        pse_pkg::ADDR_SR_SOFT:  next_st.rdata = st.sr_soft;
        pse_pkg::ADDR_STATUS: begin
          next_st.rdata[pse_pkg::ST_SYNC_BIT] = sync_lock_in;
          next_st.rdata[pse_pkg::ST_BUSY_LO +: 4] = st.sr_busy;
          next_st.rdata[pse_pkg::ST_KILL_LO +: 2] = st.kill;
        end
        default: next_st.rdata = 8'h00;
      endcase
    end

    // cycle counter over the running period
    if (cnt_plus >= period) begin
      next_st.cnt       = 16'h0000;
      next_st.cyc_start = 1'b1;
    end else begin
      next_st.cnt = cnt_plus;
    end

    // output 2 off from output 1 cycle start until its own start
    if (!sync_lock_in || !st.shutdown[pse_pkg::SD_PWM_OUTPUT_2_BIT]) begin
      next_st.kill[1] = 1'b0;
    end else if (start_hit[0]) begin
      next_st.kill[1] = 1'b1;
    end else if (start_hit[1]) begin
      next_st.kill[1] = 1'b0;
    end

    // output 1 off from output 2 cycle start until its own start
    if (!sync_lock_in || !st.shutdown[pse_pkg::SD_PWM_OUTPUT_1_BIT]) begin
      next_st.kill[0] = 1'b0;
    end else if (start_hit[1]) begin
      next_st.kill[0] = 1'b1;
    end else if (start_hit[0]) begin
      next_st.kill[0] = 1'b0;
    end

    // rectifier ramp: start late, walk the rising edge left
    for (int j = 0; j < pse_pkg::NUM_SR; j++) begin
      if (!st.sr_soft[pse_pkg::SR_EN_LO + j]) begin
        next_st.sr_off[j]  = 16'h0000;
        next_st.sr_busy[j] = 1'b0;
      end else if (sr_start_in) begin
        next_st.sr_off[j]  = sr_width[j];
        next_st.sr_busy[j] = (sr_width[j] != 16'h0000);
      end else if (sr_step && st.sr_busy[j]) begin
        if (st.sr_off[j] > pse_pkg::SR_STEP_POS) begin
          next_st.sr_off[j] = st.sr_off[j] - pse_pkg::SR_STEP_POS;
        end else begin
          next_st.sr_off[j]  = 16'h0000;
          next_st.sr_busy[j] = 1'b0;
        end
      end
    end

    // outputs with the cross shutdown applied
    next_st.pwm = on_now & ~{6'h00, st.kill};
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st          <= '0;
      st.shutdown <= pse_pkg::RST_SHUTDOWN;
      st.adjust   <= pse_pkg::RST_ADJUST;
      st.sr_soft  <= pse_pkg::RST_SR_SOFT;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out   = st.rdata;
  assign pwm_out     = st.pwm;
  assign sr_busy_out = st.sr_busy;

endmodule
